/* src/crc_link_defs.svh */
// constants for the write-crc link: frame layout, crc polynomial, alert timing
// assumes nothing; included by the package and both link ends
`ifndef CRC_LINK_DEFS_SVH
`define CRC_LINK_DEFS_SVH

// system clock of the controller end
`define CLK_PERIOD_NS      10
// crc-8 polynomial x^8+x^2+x+1, msb-first, all-zero start
`define CRC_POLY           8'h07
`define TREE_BITS          72
`define X4_DATA_BITS       32
// frame layout in link beats
`define FRAME_UI           4'hA
`define LAST_DATA_BEAT     4'h7
`define CRC_BEAT_LO        4'h8
`define CRC_BEAT_HI        4'h9
// alert pulse width in link clocks and worst alert latency
`define ALERT_PW_MIN       6
`define ALERT_PW_MAX       10
`define CRC_ALERT_MAX_NS   13
`define CRC_ALERT_MAX_CYC  (((`CRC_ALERT_MAX_NS / `CLK_PERIOD_NS) < 1) ? 1 : \
                            (`CRC_ALERT_MAX_NS / `CLK_PERIOD_NS))

`endif

/* src/crc_link_pkg.sv */
// types and shared crc arithmetic for the write-crc link
// assumes crc_link_defs.svh is on the include path
`include "crc_link_defs.svh"

package crc_link_pkg;

    // device data width, one-hot
    typedef enum logic [2:0] {
        W_X4  = 3'b001,
        W_X8  = 3'b010,
        W_X16 = 3'b100
    } width_e;

    // controller sequencer states
    typedef enum logic [3:0] {
        C_IDLE = 4'b0001,
        C_MRS  = 4'b0010,
        C_SEND = 4'b0100,
        C_WAIT = 4'b1000
    } ctl_state_e;

    // serial crc over a 72-bit code word, bit 71 first
    function automatic logic [7:0] crc8(input logic [71:0] d);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = `TREE_BITS - 1; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // tree input of one tree, with unused inputs forced to one
    function automatic logic [71:0] tree_in(input logic [143:0] d, input width_e w,
                                            input logic mask_on, input logic hi);
        logic [71:0] t;
        t = hi ? d[143:72] : d[71:0];
        if (w == W_X4) begin
            t[71:`X4_DATA_BITS] = '1;
        end else if (!mask_on) begin
            t[71:64] = 8'hFF;
        end
        return t;
    endfunction

endpackage

/* src/crc_link_if.sv */
// link between the controller end and the dram end of the write-crc path
// assumes the controller makes ck; alert_n is open-drain with a pull-up here
`timescale 1ns/10ps

interface crc_link_if;
    // link clock, driven by the controller divider
    logic                        ck;
    // write frame
    logic                        wr_start;
    logic [15:0]                 dq;
    logic [1:0]                  dm_dbi;
    // mode register set
    logic                        mrs_we;
    logic                        mrs_crc_en;
    logic                        mrs_dm_en;
    logic                        mrs_dbi_en;
    crc_link_pkg::width_e        mrs_width;
    logic                        mrs_err_clr;
    // mode register state seen by the controller
    logic                        err_clr_bit;
    logic                        err_status_bit;
    logic                        par_flag;
    // alert, open drain
    logic                        alert_drv;
    logic                        alert_oe_n;
    logic                        alert_n;

    // pull-up: line reads high whenever the device releases it
    assign alert_n = alert_oe_n ? 1'b1 : alert_drv;

    modport dev (
        input  ck, wr_start, dq, dm_dbi,
        input  mrs_we, mrs_crc_en, mrs_dm_en, mrs_dbi_en, mrs_width, mrs_err_clr,
        output err_clr_bit, err_status_bit, par_flag,
        output alert_drv, alert_oe_n
    );

    modport ctl (
        output ck, wr_start, dq, dm_dbi,
        output mrs_we, mrs_crc_en, mrs_dm_en, mrs_dbi_en, mrs_width, mrs_err_clr,
        input  err_clr_bit, err_status_bit, par_flag,
        input  alert_n
    );
endinterface

/* src/crc_dram_end.sv */
// dram end of the write-crc path: frame capture, crc check, alert pulse
// assumes the link clock ck and nrst come from the controller domain
`timescale 1ns/10ps
`include "crc_link_defs.svh"

// Overview of operation
// - x4 tree: 32 data bits, upper 40 ones
// - x4 frame: data beats 0-7, crc beats 8-9
// - x8 host sends ones in beat 9
// - x8 mask lane feeds tree only if enabled
// - host never enables dbi and mask together
// - x8 frame: crc on beat 8, beat 9 ones
// - x16 host sends ones in beat 9
// - x16 uses two identical 72-input trees
// - x16 mask inputs forced one when disabled
// - x16 upper byte lanes carry D72-D143
// - crc errors share the parity alert line
// - crc error shown as alert pulse and flag bits
// - error sets clear bit and status bit
// - clear bit holds until host mrs clear
// - host retries writes after alert pulse
// - host keeps retried writes coherent
// - host accepts stretched shared alert pulse
// - device pulls low then releases, pull-up restores
// - crc-8 x8+x2+x+1, zero start, bit 71 first
// - compare checksums, commit without waiting
// - alert within 13 ns, 6 to 10 clocks
// - crc frames always ten beats long
module crc_dram_end #(
    parameter int unsigned ALERT_PW = `ALERT_PW_MIN
) (
    // link side, ck domain
    input  wire logic   nrst,
    crc_link_if.dev     link,
    // array side
    output logic [143:0] wr_data,
    output logic         wr_commit,
    output logic         crc_err,
    // command/address parity error from the decoder
    input  wire logic    par_err
);

    // mode register copies
    logic                 crc_en_q;
    logic                 dm_en_q;
    logic                 dbi_en_q;
    crc_link_pkg::width_e width_q;
    // frame capture
    logic                 active_q;
    logic [3:0]           beat_q;
    logic [143:0]         d_q;
    logic [17:0]          rx8_q;
    logic [17:0]          lanes;
    // check
    logic [7:0]           rx_lo;
    logic [7:0]           rx_hi;
    logic                 mask_on;
    logic                 last_beat;
    logic                 mismatch;
    logic                 err_now;
    // alert pulse and flags
    logic [3:0]           pw_q;
    logic                 oe_n_q;
    logic                 clr_bit_q;
    logic                 status_q;
    logic                 par_q;
    logic [143:0]         wr_data_q;
    logic                 commit_q;
    logic                 crc_err_q;

    // lane k of a data beat carries D[8k+t]: dq0-7, ldm, dq8-15, udm
    assign lanes = {link.dm_dbi[1], link.dq[15:8], link.dm_dbi[0], link.dq[7:0]};

    // mode register set; dm and dbi are taken as written, host keeps them apart
    always_ff @(posedge link.ck) begin
        if (!nrst) begin
            crc_en_q <= 1'b0;
            dm_en_q  <= 1'b0;
            dbi_en_q <= 1'b0;
            width_q  <= crc_link_pkg::W_X8;
        end else if (link.mrs_we) begin
            crc_en_q <= link.mrs_crc_en;
            dm_en_q  <= link.mrs_dm_en;
            dbi_en_q <= link.mrs_dbi_en;
            width_q  <= link.mrs_width;
        end
    end

    // frame capture: ten beats from wr_start, starts inside a frame ignored
    always_ff @(posedge link.ck) begin
        if (!nrst) begin
            active_q <= 1'b0;
            beat_q   <= 4'h0;
            d_q      <= '0;
            rx8_q    <= '1;
        end else begin
            if (!active_q && link.wr_start) begin
                active_q <= 1'b1;
                beat_q   <= 4'h1;
                for (int k = 0; k < 18; k++) begin
                    d_q[8 * k] <= lanes[k];
                end
            end else if (active_q) begin
                if (beat_q <= `LAST_DATA_BEAT) begin
                    for (int k = 0; k < 18; k++) begin
                        d_q[8 * k + int'(beat_q)] <= lanes[k];
                    end
                end
                if (beat_q == `CRC_BEAT_LO) begin
                    rx8_q <= lanes;
                end
                if (beat_q == `CRC_BEAT_HI) begin
                    active_q <= 1'b0;
                    beat_q   <= 4'h0;
                end else begin
                    beat_q <= beat_q + 4'h1;
                end
            end
        end
    end

    // received checksum; x4 splits it over beats 8 and 9 on dq0-3
    always_comb begin
        if (width_q == crc_link_pkg::W_X4) begin
            rx_lo = {lanes[3:0], rx8_q[3:0]};
        end else begin
            rx_lo = rx8_q[7:0];
        end
        rx_hi = rx8_q[16:9];
    end

    // check on the last beat, so the alert leaves with no extra clock
    assign mask_on   = dm_en_q | dbi_en_q;
    assign last_beat = active_q && (beat_q == `CRC_BEAT_HI);
    always_comb begin
        mismatch = crc_link_pkg::crc8(crc_link_pkg::tree_in(d_q, width_q, mask_on, 1'b0))
                   != rx_lo;
        if (width_q == crc_link_pkg::W_X16) begin
            mismatch = mismatch |
                (crc_link_pkg::crc8(crc_link_pkg::tree_in(d_q, width_q, mask_on, 1'b1))
                 != rx_hi);
        end
    end
    assign err_now = last_beat && crc_en_q && mismatch;

    // commit to the array regardless of the check result
    always_ff @(posedge link.ck) begin
        if (!nrst) begin
            wr_data_q <= '0;
            commit_q  <= 1'b0;
            crc_err_q <= 1'b0;
        end else begin
            commit_q  <= last_beat;
            crc_err_q <= err_now;
            if (last_beat) begin
                wr_data_q <= d_q;
            end
        end
    end

    // alert pulse: crc and parity errors share the line, retrigger stretches it
    always_ff @(posedge link.ck) begin
        if (!nrst) begin
            pw_q   <= 4'h0;
            oe_n_q <= 1'b1;
        end else if (err_now || par_err) begin
            pw_q   <= 4'(ALERT_PW);
            oe_n_q <= 1'b0;
        end else if (pw_q > 4'h1) begin
            pw_q <= pw_q - 4'h1;
        end else begin
            pw_q   <= 4'h0;
            oe_n_q <= 1'b1;
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge link.ck) begin
        if (!nrst) begin
            clr_bit_q <= 1'b0;
            status_q  <= 1'b0;
            par_q     <= 1'b0;
        end else begin
            if (err_now) begin
                clr_bit_q <= 1'b1;
                status_q  <= 1'b1;
            end else if (link.mrs_we && link.mrs_err_clr) begin
                clr_bit_q <= 1'b0;
                status_q  <= 1'b0;
            end
            if (par_err) begin
                par_q <= 1'b1;
            end else if (link.mrs_we && link.mrs_err_clr) begin
                par_q <= 1'b0;
            end
        end
    end

    // only ever pull low; the pull-up lives in the link interface
    assign link.alert_drv      = 1'b0;
    assign link.alert_oe_n     = oe_n_q;
    assign link.err_clr_bit    = clr_bit_q;
    assign link.err_status_bit = status_q;
    assign link.par_flag       = par_q;
    assign wr_data             = wr_data_q;
    assign wr_commit           = commit_q;
    assign crc_err             = crc_err_q;

endmodule

/* src/crc_ctrl_end.sv */
// controller end: builds crc frames, makes the link clock, retries on alert
// assumes a 100 MHz clock; alert_n and mode bits come back asynchronously
`timescale 1ns/10ps
`include "crc_link_defs.svh"

module crc_ctrl_end #(
    parameter int unsigned CK_HALF    = 2,
    parameter int unsigned RETRY_WAIT = `CRC_ALERT_MAX_CYC + 4 * CK_HALF + 2
) (
    // system side
    input  wire logic                 clock,
    input  wire logic                 nrst,
    // mode register set request
    input  wire logic                 cfg_req,
    input  wire logic                 cfg_crc_en,
    input  wire logic                 cfg_dm_en,
    input  wire logic                 cfg_dbi_en,
    input  crc_link_pkg::width_e      cfg_width,
    input  wire logic                 cfg_err_clr,
    output logic                      cfg_ready,
    // write request, D-numbered code word
    input  wire logic                 wr_req,
    input  wire logic [143:0]         wr_data,
    input  wire logic                 wr_inject,
    output logic                      wr_ready,
    // results
    output logic                      wr_done,
    output logic                      retry,
    output logic                      err_clr_seen,
    output logic                      err_status_seen,
    output logic                      par_seen,
    // link
    crc_link_if.ctl                   link
);

    crc_link_pkg::ctl_state_e st_q;
    crc_link_pkg::width_e     width_q;
    // divider starts from a known value; it has no reset so ck runs in reset
    logic [7:0]   div_q = 8'h00;
    logic         ck_q = 1'b0;
    logic         fall;
    logic [3:0]   beat_q;
    logic [143:0] data_q;
    logic [7:0]   crc_lo_q;
    logic [7:0]   crc_hi_q;
    logic         crc_en_q;
    logic         dm_q;
    logic         dbi_q;
    logic         clr_q;
    logic [17:0]  lanes_q;
    logic         start_q;
    logic         mrs_we_q;
    logic [7:0]   wait_q;
    logic         seen_q;
    logic [1:0]   alert_s_q;
    logic         alert_d_q;
    logic [2:0]   bits_m_q;
    logic [2:0]   bits_s_q;
    logic         done_q;
    logic         retry_q;
    logic         mask_on;
    logic         alert_fall;

    // lanes of one beat; unused lanes and lanes past the data stay one
    function automatic logic [17:0] beat_lanes(input logic [3:0] t, input logic [143:0] d,
                                               input logic [7:0] lo, input logic [7:0] hi,
                                               input crc_link_pkg::width_e w,
                                               input logic m);
        logic [17:0] l;
        l = '1;
        for (int k = 0; k < 18; k++) begin
            if (t <= `LAST_DATA_BEAT) begin
                l[k] = d[8 * k + int'(t)];
            end
        end
        if (t == `CRC_BEAT_LO) begin
            l[7:0]  = lo;
            l[16:9] = hi;
        end
        if (t == `CRC_BEAT_HI && w == crc_link_pkg::W_X4) begin
            l[3:0] = lo[7:4];
        end
        if (w == crc_link_pkg::W_X4) begin
            l[17:4] = '1;
        end else if (w == crc_link_pkg::W_X8) begin
            l[17:9] = '1;
        end
        if (!m) begin
            l[8]  = 1'b1;
            l[17] = 1'b1;
        end
        return l;
    endfunction

    // link clock divider; runs through reset so the dram end can reset
    always_ff @(posedge clock) begin
        if (div_q == 8'(CK_HALF - 1)) begin
            div_q <= 8'h00;
            ck_q  <= ~ck_q;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign fall = ck_q && (div_q == 8'(CK_HALF - 1));

    // alert and mode bits are asynchronous here: two flops first
    always_ff @(posedge clock) begin
        if (!nrst) begin
            alert_s_q <= 2'h3;
            alert_d_q <= 1'b1;
            bits_m_q  <= 3'h0;
            bits_s_q  <= 3'h0;
        end else begin
            alert_s_q <= {alert_s_q[0], link.alert_n};
            alert_d_q <= alert_s_q[1];
            bits_m_q  <= {link.par_flag, link.err_status_bit, link.err_clr_bit};
            bits_s_q  <= bits_m_q;
        end
    end
    assign alert_fall = alert_d_q && !alert_s_q[1];
    assign mask_on    = dm_q | dbi_q;

    // sequencer: mrs, frame, then a wait long enough for the worst alert
    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q     <= crc_link_pkg::C_IDLE;
            beat_q   <= 4'h0;
            wait_q   <= 8'h00;
            seen_q   <= 1'b0;
            done_q   <= 1'b0;
            retry_q  <= 1'b0;
            data_q   <= '0;
            crc_lo_q <= 8'h00;
            crc_hi_q <= 8'h00;
        end else begin
            done_q  <= 1'b0;
            retry_q <= 1'b0;
            if (alert_fall) begin
                seen_q <= 1'b1;
            end
            unique case (st_q)
                crc_link_pkg::C_IDLE: begin
                    beat_q <= 4'h0;
                    if (cfg_req) begin
                        st_q <= crc_link_pkg::C_MRS;
                    end else if (wr_req) begin
                        st_q     <= crc_link_pkg::C_SEND;
                        seen_q   <= 1'b0;
                        data_q   <= wr_data;
                        crc_lo_q <= crc_link_pkg::crc8(crc_link_pkg::tree_in(wr_data,
                                    width_q, mask_on, 1'b0)) ^ {7'h00, wr_inject};
                        crc_hi_q <= crc_link_pkg::crc8(crc_link_pkg::tree_in(wr_data,
                                    width_q, mask_on, 1'b1));
                    end
                end
                crc_link_pkg::C_MRS: begin
                    if (fall) begin
                        beat_q <= beat_q + 4'h1;
                        if (beat_q == 4'h1) begin
                            st_q <= crc_link_pkg::C_IDLE;
                        end
                    end
                end
                crc_link_pkg::C_SEND: begin
                    if (fall) begin
                        if (beat_q == `FRAME_UI) begin
                            st_q   <= crc_link_pkg::C_WAIT;
                            wait_q <= 8'(RETRY_WAIT);
                        end else begin
                            beat_q <= beat_q + 4'h1;
                        end
                    end
                end
                crc_link_pkg::C_WAIT: begin
                    if (wait_q != 8'h00) begin
                        wait_q <= wait_q - 8'h01;
                    end else if (alert_s_q[1]) begin
                        // a stretched shared pulse just delays this exit
                        beat_q <= 4'h0;
                        if (seen_q || alert_fall) begin
                            st_q     <= crc_link_pkg::C_SEND;
                            seen_q   <= 1'b0;
                            retry_q  <= 1'b1;
                            crc_lo_q <= crc_link_pkg::crc8(crc_link_pkg::tree_in(data_q,
                                        width_q, mask_on, 1'b0));
                        end else begin
                            st_q   <= crc_link_pkg::C_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // mode copy; dm wins over dbi so both are never on
    always_ff @(posedge clock) begin
        if (!nrst) begin
            crc_en_q <= 1'b0;
            dm_q     <= 1'b0;
            dbi_q    <= 1'b0;
            clr_q    <= 1'b0;
            width_q  <= crc_link_pkg::W_X8;
        end else if (st_q == crc_link_pkg::C_IDLE && cfg_req) begin
            crc_en_q <= cfg_crc_en;
            dm_q     <= cfg_dm_en;
            dbi_q    <= cfg_dbi_en & ~cfg_dm_en;
            clr_q    <= cfg_err_clr;
            width_q  <= cfg_width;
        end
    end

    // pins change on the falling link edge, dram samples on the rising one
    always_ff @(posedge clock) begin
        if (!nrst) begin
            lanes_q  <= '1;
            start_q  <= 1'b0;
            mrs_we_q <= 1'b0;
        end else if (fall) begin
            mrs_we_q <= (st_q == crc_link_pkg::C_MRS) && (beat_q == 4'h0);
            start_q  <= (st_q == crc_link_pkg::C_SEND) && (beat_q == 4'h0);
            if (st_q == crc_link_pkg::C_SEND && beat_q != `FRAME_UI) begin
                lanes_q <= beat_lanes(beat_q, data_q, crc_lo_q, crc_hi_q,
                                      width_q, mask_on);
            end else begin
                lanes_q <= '1;
            end
        end
    end

    assign link.ck          = ck_q;
    assign link.wr_start    = start_q;
    assign link.dq          = {lanes_q[16:9], lanes_q[7:0]};
    assign link.dm_dbi      = {lanes_q[17], lanes_q[8]};
    assign link.mrs_we      = mrs_we_q;
    assign link.mrs_crc_en  = crc_en_q;
    assign link.mrs_dm_en   = dm_q;
    assign link.mrs_dbi_en  = dbi_q;
    assign link.mrs_width   = width_q;
    assign link.mrs_err_clr = clr_q;
    assign cfg_ready        = (st_q == crc_link_pkg::C_IDLE);
    assign wr_ready         = (st_q == crc_link_pkg::C_IDLE) && !cfg_req;
    assign wr_done          = done_q;
    assign retry            = retry_q;
    assign err_clr_seen     = bits_s_q[0];
    assign err_status_seen  = bits_s_q[1];
    assign par_seen         = bits_s_q[2];

endmodule

/* verification/crc_link_checker.sv */
// link-wire checker for the write-crc path
// assumes it sits beside the link interface, all in the ck domain
`timescale 1ns/10ps
module crc_link_checker (
    // link clock and reset
    input  wire logic            ck,
    input  wire logic            nrst,
    // frame and mode wires
    input  wire logic            wr_start,
    input  wire logic [15:0]     dq,
    input  wire logic [1:0]      dm_dbi,
    input  wire logic            mrs_we,
    input  wire logic            mrs_crc_en,
    input  wire logic            mrs_err_clr,
    input  crc_link_pkg::width_e mrs_width,
    // device answers
    input  wire logic            err_clr_bit,
    input  wire logic            err_status_bit,
    input  wire logic            par_flag,
    input  wire logic            alert_oe_n
);
    default clocking @(posedge ck); endclocking
    default disable iff (!nrst);

    // pulse shape: six low samples, released by ten
    pulse_min_a: assert property ($fell(alert_oe_n) |-> !alert_oe_n [*6])
        else $error("alert pulse too short");
    pulse_end_a: assert property ($fell(alert_oe_n) |-> ##[6:10] alert_oe_n)
        else $error("alert not released in time");
    // alert right after beat 9, or from a parity error
    alert_cause_a: assert property ($fell(alert_oe_n) |->
        $past(wr_start, 10) or ##[0:2] par_flag)
        else $error("alert without frame end");
    flag_pair_a: assert property ($rose(err_clr_bit) |-> err_status_bit)
        else $error("status bit missing");
    flag_cause_a: assert property ($rose(err_clr_bit) |-> ##[0:2] !alert_oe_n)
        else $error("flag set without alert");
    clr_hold_a: assert property (err_clr_bit && !(mrs_we && mrs_err_clr) |=> err_clr_bit)
        else $error("clear bit dropped");
    crc_off_a: assert property (wr_start && !mrs_crc_en |-> ##10 alert_oe_n [*2])
        else $error("alert with crc off");
    beat8_ones_a: assert property ($past(wr_start, 8) && mrs_crc_en |-> dm_dbi == 2'h3)
        else $error("mask lanes not ones in beat 8");
    beat9_ones_a: assert property ($past(wr_start, 9) && mrs_crc_en &&
        mrs_width != crc_link_pkg::W_X4 |-> dq == 16'hFFFF && dm_dbi == 2'h3)
        else $error("beat 9 not all ones");
endmodule

/* verification/write_crc_check_and_alert_test.sv */
// bench: controller end and dram end joined by the link interface
// assumes the controller makes the link clock from clock
`timescale 1ns/10ps
module write_crc_check_and_alert_test;
    localparam logic [143:0] PAT = 144'h1234_5678_9ABC_DEF0_0FED_CBA9_8765_4321_C3A5;
    logic clock = 1'b0, nrst = 1'b0, cfg_req = 1'b0, cfg_crc_en = 1'b0, cfg_dm_en = 1'b0;
    logic cfg_dbi_en = 1'b0, cfg_err_clr = 1'b0, wr_req = 1'b0, wr_inject = 1'b0;
    logic par_err = 1'b0, cfg_ready, wr_ready, wr_done, retry, dev_commit, dev_crc_err;
    logic err_clr_seen, err_status_seen, par_seen, saw;
    logic [143:0] wr_data = '0, dev_data, got_q;
    crc_link_pkg::width_e cfg_width = crc_link_pkg::W_X8;
    int err_total = 0, compares = 0, crc_hits = 0;

    crc_link_if lnk ();
    crc_ctrl_end i_crc_ctrl_end (.clock, .nrst, .cfg_req, .cfg_crc_en, .cfg_dm_en,
        .cfg_dbi_en, .cfg_width, .cfg_err_clr, .cfg_ready, .wr_req, .wr_data, .wr_inject,
        .wr_ready, .wr_done, .retry, .err_clr_seen, .err_status_seen, .par_seen,
        .link(lnk.ctl));
    crc_dram_end i_crc_dram_end (.nrst, .link(lnk.dev), .wr_data(dev_data),
        .wr_commit(dev_commit), .crc_err(dev_crc_err), .par_err);
    crc_link_checker i_crc_link_checker (.ck(lnk.ck), .nrst, .wr_start(lnk.wr_start),
        .dq(lnk.dq), .dm_dbi(lnk.dm_dbi), .mrs_we(lnk.mrs_we), .mrs_crc_en(lnk.mrs_crc_en),
        .mrs_err_clr(lnk.mrs_err_clr), .mrs_width(lnk.mrs_width),
        .err_clr_bit(lnk.err_clr_bit), .err_status_bit(lnk.err_status_bit),
        .par_flag(lnk.par_flag), .alert_oe_n(lnk.alert_oe_n));

    always #5 clock = ~clock;
    // keep what the array was handed; commit is a single ck pulse
    always @(posedge lnk.ck) if (dev_commit === 1'b1) got_q <= dev_data;
    // count the device's own mismatch pulses
    always @(posedge lnk.ck) if (dev_crc_err === 1'b1) crc_hits <= crc_hits + 1;

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: flag %b, want %b", $time, got, exp);
        end
    endtask
    task automatic chkv(input logic [143:0] got, input logic [143:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: data %h, want %h", $time, got, exp);
        end
    endtask
    // mode write; long settle so the 2-flop flag syncs catch up
    task automatic cfg(input logic crc, input logic [1:0] m, input logic clr,
                       input crc_link_pkg::width_e w);
        @(negedge clock);
        cfg_crc_en = crc;
        cfg_dm_en = m[0];
        cfg_dbi_en = m[1];
        cfg_err_clr = clr;
        cfg_width = w;
        cfg_req = 1'b1;
        while (cfg_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        cfg_req = 1'b0;
        while (cfg_ready !== 1'b1) @(negedge clock);
        repeat (20) @(negedge clock);
    endtask
    // one write, retry noted until done
    task automatic wr(input logic inj, input logic exp_retry);
        int base;
        @(negedge clock);
        base = crc_hits;
        wr_data = PAT;
        wr_inject = inj;
        wr_req = 1'b1;
        while (wr_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        wr_req = 1'b0;
        saw = 1'b0;
        for (int n = 0; n < 400 && wr_done !== 1'b1; n++) begin
            @(negedge clock);
            if (retry === 1'b1) saw = 1'b1;
        end
        chk1(saw, exp_retry);
        chk1(wr_done, 1'b1);
        chk1(crc_hits != base, exp_retry);
        repeat (20) @(negedge clock);
    endtask

    task automatic t_x8;
        cfg(1'b1, 2'h0, 1'b0, crc_link_pkg::W_X8);
        wr(1'b0, 1'b0);
        chkv(got_q[63:0], PAT[63:0]);
        wr(1'b1, 1'b1);
        chk1(err_clr_seen, 1'b1);
        chk1(err_status_seen, 1'b1);
        repeat (60) @(negedge clock);
        chk1(err_clr_seen, 1'b1);
        cfg(1'b1, 2'h1, 1'b1, crc_link_pkg::W_X8);
        chk1(err_clr_seen, 1'b0);
        wr(1'b0, 1'b0);
        chkv(got_q[71:0], PAT[71:0]);
        wr(1'b1, 1'b1);
    endtask
    task automatic t_x4;
        cfg(1'b1, 2'h0, 1'b1, crc_link_pkg::W_X4);
        wr(1'b0, 1'b0);
        chkv(got_q[31:0], PAT[31:0]);
        wr(1'b1, 1'b1);
    endtask
    task automatic t_x16;
        cfg(1'b1, 2'h2, 1'b1, crc_link_pkg::W_X16);
        wr(1'b0, 1'b0);
        chkv(got_q, PAT);
        wr(1'b1, 1'b1);
        cfg(1'b1, 2'h0, 1'b1, crc_link_pkg::W_X16);
        wr(1'b0, 1'b0);
    endtask
    task automatic t_off;
        cfg(1'b0, 2'h0, 1'b1, crc_link_pkg::W_X8);
        wr(1'b1, 1'b0);
        chk1(err_clr_seen, 1'b0);
    endtask
    task automatic t_par;
        @(negedge lnk.ck) par_err = 1'b1;
        @(negedge lnk.ck) par_err = 1'b0;
        repeat (30) @(negedge clock);
        chk1(par_seen, 1'b1);
        chk1(err_clr_seen, 1'b0);
    endtask

    task automatic tally_and_finish;
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // about 1300 clocks of traffic; the watchdog allows several times that
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        t_x8();
        t_x4();
        t_x16();
        t_off();
        t_par();
        tally_and_finish();
    end
endmodule
